// >>> core/dwl_level.v
`timescale 1ns/100ps
`include "dwl_map.vh"
module dwl_level #(
  parameter LANES  = `DWL_LANES,
  parameter LANE_W = `DWL_LANE_W
) (
  // Clock and reset
  input  wire                          sys_clk_in,
  input  wire                          rst_n_in,
  // Mode register write, same clock domain
  input  wire                          mrs_wr_in,
  input  wire [`DWL_MR_SEL_W-1:0]      mrs_sel_in,
  input  wire [`DWL_ADDR_W-1:0]        mrs_addr_in,
  // Pins from the controller
  input  wire                          ck_in,
  input  wire [LANES-1:0]              dqs_in,
  input  wire                          odt_in,
  // Data pins and status
  output wire [LANES*LANE_W-1:0]       dq_out,
  output wire [LANES*LANE_W-1:0]       dq_oe_out,
  output wire                          dq_undef_out,
  output wire [LANES-1:0]              dqs_oe_out,
  output wire                          rtt_dqs_on_out,
  output wire                          rtt_dq_on_out,
  output wire                          level_mode_out,
  output wire                          qoff_out
);

  // ==========================================================
  // Derived cycle counts
  localparam TMOD_RAW = (`DWL_TMOD_NS + `DWL_CLK_NS - 1) / `DWL_CLK_NS;
  localparam TMOD_CYC = (TMOD_RAW < 1) ? 1 : TMOD_RAW;
  localparam [`DWL_CNT_W-1:0] TMOD_C = TMOD_CYC[`DWL_CNT_W-1:0];
  localparam [`DWL_CNT_W-1:0] CNT_ONE = 8'h01;
  localparam [`DWL_CNT_W-1:0] CNT_ZERO = 8'h00;

  // ==========================================================
  // Pin synchronisers
  wire             ck_s2_q;
  wire             odt_s2_q;
  wire [LANES-1:0] dqs_s2_q;
  reg  [LANES-1:0] dqs_s3_q;

  dwl_sync #(
    .W          (1)
  ) ck_sync_inst (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .pin_in     (ck_in),
    .sync_out   (ck_s2_q)
  );

  dwl_sync #(
    .W          (1)
  ) odt_sync_inst (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .pin_in     (odt_in),
    .sync_out   (odt_s2_q)
  );

  dwl_sync #(
    .W          (LANES)
  ) dqs_sync_inst (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .pin_in     (dqs_in),
    .sync_out   (dqs_s2_q)
  );

  // Strobe edge history, idle low like the pin
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dqs_s3_q <= {LANES{1'b0}};
    end else begin
      dqs_s3_q <= dqs_s2_q;
    end
  end

  wire [LANES-1:0] dqs_rise = dqs_s2_q & ~dqs_s3_q;

  // ==========================================================
  // Mode register state
  reg                  level_q;
  reg                  qoff_q;
  reg                  undef_q;
  reg [`DWL_CNT_W-1:0] exit_cnt_q;
  wire                 mr1_wr = mrs_wr_in && (mrs_sel_in == `DWL_MR1_SEL);
  wire                 lvl_bit = mrs_addr_in[`DWL_LVL_BIT];
  wire [LANES-1:0]     fb_valid;

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level_q    <= 1'b0;
      qoff_q     <= 1'b0;
      undef_q    <= 1'b0;
      exit_cnt_q <= CNT_ZERO;
    end else begin
      if (mr1_wr) begin
        level_q <= lvl_bit;
        qoff_q  <= mrs_addr_in[`DWL_QOFF_BIT];
      end
      if (mr1_wr && lvl_bit && !level_q) begin
        undef_q    <= 1'b1;
        exit_cnt_q <= CNT_ZERO;
      end else if (mr1_wr && !lvl_bit && level_q) begin
        undef_q    <= 1'b1;
        exit_cnt_q <= TMOD_C;
      end else if (exit_cnt_q != CNT_ZERO) begin
        exit_cnt_q <= exit_cnt_q - CNT_ONE;
        if (exit_cnt_q == CNT_ONE) begin
          undef_q <= 1'b0;
        end
      end else if (level_q && (|fb_valid)) begin
        undef_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Per lane feedback
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : lane
      dwl_lane #(
        .LANE_W     (LANE_W)
      ) dwl_lane_inst (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .level_in   (level_q),
        .rise_in    (dqs_rise[g]),
        .ck_lvl_in  (ck_s2_q),
        .dq_out     (dq_out[g*LANE_W +: LANE_W]),
        .valid_out  (fb_valid[g])
      );
    end
  endgenerate

  // ==========================================================
  // Pin drive and termination
  wire drive_en = level_q && !qoff_q;

  assign dq_oe_out      = {(LANES*LANE_W){drive_en}};
  assign dqs_oe_out     = {LANES{1'b0}};
  assign dq_undef_out   = undef_q;
  assign rtt_dqs_on_out = odt_s2_q;
  assign rtt_dq_on_out  = odt_s2_q && !level_q;
  assign level_mode_out = level_q;
  assign qoff_out       = qoff_q;

endmodule

// ==========================================================
// Two stage pin synchroniser
module dwl_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         sys_clk_in,
  input  wire         rst_n_in,
  // Pin in, synchronised level out
  input  wire [W-1:0] pin_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
    end
  end

  assign sync_out = s2_q;

endmodule

// ==========================================================
// One byte lane of leveling feedback
module dwl_lane #(
  parameter LANE_W = `DWL_LANE_W
) (
  // Clock and reset
  input  wire              sys_clk_in,
  input  wire              rst_n_in,
  // Leveling state and synchronised pins
  input  wire              level_in,
  input  wire              rise_in,
  input  wire              ck_lvl_in,
  // Feedback
  output wire [LANE_W-1:0] dq_out,
  output wire              valid_out
);

  localparam TWLO_RAW = `DWL_TWLO_NS / `DWL_CLK_NS;
  localparam TWLO_CYC = (TWLO_RAW < 1) ? 1 : TWLO_RAW;
  localparam [`DWL_CNT_W-1:0] TWLO_C   = TWLO_CYC[`DWL_CNT_W-1:0];
  localparam [`DWL_CNT_W-1:0] CNT_ONE  = 8'h01;
  localparam [`DWL_CNT_W-1:0] CNT_ZERO = 8'h00;

  reg                  samp_q;
  reg                  fb_q;
  reg                  valid_q;
  reg [`DWL_CNT_W-1:0] wlo_cnt_q;

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      samp_q    <= 1'b0;
      fb_q      <= 1'b0;
      valid_q   <= 1'b0;
      wlo_cnt_q <= CNT_ZERO;
    end else if (!level_in) begin
      fb_q      <= 1'b0;
      valid_q   <= 1'b0;
      wlo_cnt_q <= CNT_ZERO;
    end else if (rise_in) begin
      samp_q    <= ck_lvl_in;
      wlo_cnt_q <= TWLO_C;
    end else if (wlo_cnt_q != CNT_ZERO) begin
      wlo_cnt_q <= wlo_cnt_q - CNT_ONE;
      if (wlo_cnt_q == CNT_ONE) begin
        fb_q    <= samp_q;
        valid_q <= 1'b1;
      end
    end
  end

  assign valid_out = valid_q;
  assign dq_out    = {{(LANE_W-1){1'b0}}, fb_q} << `DWL_PRIME_BIT;

endmodule

// >>> include/dwl_map.vh
`ifndef DWL_MAP_VH
`define DWL_MAP_VH
// ==========================================================
// Mode register selection and fields
`define DWL_MR_SEL_W      2
`define DWL_MR1_SEL       2'h1
`define DWL_ADDR_W        16
`define DWL_LVL_BIT       7
`define DWL_QOFF_BIT      12
// ==========================================================
// Lane layout
`define DWL_LANES         2
`define DWL_LANE_W        8
`define DWL_PRIME_BIT     0
// ==========================================================
// Timing in nanoseconds, counter width in bits
`define DWL_CLK_NS        50
`define DWL_TMOD_NS       15
`define DWL_TWLO_NS       7
`define DWL_CNT_W         8
`endif

// >>> test/dwl_ctrl_model.sv
`timescale 1ns/100ps
module dwl_ctrl_model (
  // Clock
  input  wire        sys_clk_in,
  // Pins to the device
  output reg         mrs_wr_out,
  output reg  [1:0]  mrs_sel_out,
  output reg  [15:0] mrs_addr_out,
  output reg         ck_out,
  output reg  [1:0]  dqs_out,
  output reg         odt_out
);
  initial begin
    {mrs_wr_out, mrs_sel_out, mrs_addr_out, dqs_out, odt_out} = 22'h000000;
    ck_out = 1'b0;
    #37;
    forever #200 ck_out = ~ck_out;
  end
  // ==========================================================
  // One-cycle mode write
  task mrs(input [1:0] sel, input [15:0] addr); begin
    mrs_wr_out   <= 1'b1;
    mrs_sel_out  <= sel;
    mrs_addr_out <= addr;
    @(posedge sys_clk_in);
    mrs_wr_out <= 1'b0;
    @(posedge sys_clk_in);
  end endtask
  // Single strobe, 2 cycles high, 4 low; returns sampled clock
  task strobe(input integer lane, output reg lvl); begin
    dqs_out[lane] <= 1'b1;
    @(posedge sys_clk_in);
    lvl = ck_out;
    @(posedge sys_clk_in);
    dqs_out[lane] <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
  end endtask
endmodule

// >>> test/dwl_props_properties.sv
`timescale 1ns/100ps
`include "dwl_map.vh"
module dwl_props #(
  parameter LANES  = 2,
  parameter LANE_W = 8
) (
  // Clock, reset, mode write
  input wire                        sys_clk_in,
  input wire                        rst_n_in,
  input wire                        mrs_wr_in,
  input wire [`DWL_MR_SEL_W-1:0]    mrs_sel_in,
  input wire [`DWL_ADDR_W-1:0]      mrs_addr_in,
  // Pins and status
  input wire                        ck_in,
  input wire [LANES-1:0]            dqs_in,
  input wire [LANES*LANE_W-1:0]     dq_out,
  input wire                        dq_undef_out,
  input wire [LANES-1:0]            dqs_oe_out,
  input wire                        rtt_dq_on_out,
  input wire                        level_mode_out
);
  localparam [LANE_W-1:0] PM = 1 << `DWL_PRIME_BIT;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================
  // Properties
  property p_mode;
    mrs_wr_in && mrs_sel_in == `DWL_MR1_SEL |=>
      level_mode_out == $past(mrs_addr_in[`DWL_LVL_BIT]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode bit not followed");
  property p_refuse;
    mrs_wr_in && mrs_sel_in != `DWL_MR1_SEL |=> $stable(level_mode_out);
  endproperty
  a_refuse: assert property (p_refuse) else $error("other select changed mode");
  property p_rtt;
    level_mode_out |-> !rtt_dq_on_out;
  endproperty
  a_rtt: assert property (p_rtt) else $error("dq termination on in leveling");
  property p_rdqs;
    dqs_oe_out == {LANES{1'b0}};
  endproperty
  a_rdqs: assert property (p_rdqs) else $error("read strobe driven");
  property p_prime;
    (dq_out & ~{LANES{PM}}) == 0;
  endproperty
  a_prime: assert property (p_prime) else $error("non-prime dq not low");
  property p_fb;
    logic v;
    ($rose(dqs_in[0]) && level_mode_out, v = ck_in) |-> ##4 dq_out[0] == v;
  endproperty
  a_fb: assert property (p_fb) else $error("feedback not clock level");
  property p_entry;
    $rose(level_mode_out) |-> dq_undef_out;
  endproperty
  a_entry: assert property (p_entry) else $error("dq defined at entry");
  property p_exit;
    $fell(level_mode_out) |-> dq_undef_out ##1 !dq_undef_out;
  endproperty
  a_exit: assert property (p_exit) else $error("undefined span wrong at exit");
  c_enter: cover property ($rose(level_mode_out));
  c_fb: cover property ($rose(dq_out[0]));
  c_fb_upper: cover property ($rose(dq_out[LANE_W]));
  c_exit: cover property ($fell(level_mode_out));
endmodule
bind dwl_level dwl_props #(.LANES(LANES), .LANE_W(LANE_W)) dwl_props_inst (.*);

// >>> test/tb.sv
`timescale 1ns/100ps
module tb;
  reg sys_clk_in = 1'b0;
  reg rst_n_in = 1'b0;
  wire mrs_wr, ck, odt, undef, rtt_dqs, rtt_dq, lvl_mode, qoff;
  wire [1:0] sel, dqs, dqs_oe;
  wire [15:0] addr, dq, dq_oe;
  reg [19:0] rows [0:5];
  integer err_count = 0, num_checks = 0, i, d;
  reg lvl, prev, locked;
  dwl_level dwl_level_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .mrs_wr_in(mrs_wr),
    .mrs_sel_in(sel), .mrs_addr_in(addr), .ck_in(ck), .dqs_in(dqs), .odt_in(odt), .dq_out(dq),
    .dq_oe_out(dq_oe), .dq_undef_out(undef), .dqs_oe_out(dqs_oe), .rtt_dqs_on_out(rtt_dqs),
    .rtt_dq_on_out(rtt_dq), .level_mode_out(lvl_mode), .qoff_out(qoff));
  dwl_ctrl_model m (.sys_clk_in(sys_clk_in), .mrs_wr_out(mrs_wr), .mrs_sel_out(sel),
    .mrs_addr_out(addr), .ck_out(ck), .dqs_out(dqs), .odt_out(odt));
  task chk1(input [8*12-1:0] n, input e, input g); begin
    num_checks = num_checks + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("mismatch %0s exp %b got %b", n, e, g);
    end
  end endtask
  task chk16(input [8*12-1:0] n, input [15:0] e, input [15:0] g); begin
    num_checks = num_checks + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("mismatch %0s exp %h got %h", n, e, g);
    end
  end endtask
  task complete_run; begin
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  end endtask
  initial forever #25 sys_clk_in = ~sys_clk_in;
  initial begin
    #200000;
    err_count = err_count + 1;
    complete_run;
  end
  initial begin
    // Rows: level, qoff, select, address
    rows[0] = 20'h90080;
    rows[1] = 20'hD1080;
    rows[2] = 20'hE0000;
    rows[3] = 20'h10000;
    rows[4] = 20'h01080;
    rows[5] = 20'h51000;
    repeat (10) @(posedge sys_clk_in);
    chk1("reset_mode", 1'b0, lvl_mode);
    chk16("reset_dq", 16'h0000, dq);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    for (i = 0; i < 6; i = i + 1) begin
      m.mrs(rows[i][17:16], rows[i][15:0]);
      chk1("level_mode", rows[i][19], lvl_mode);
      chk1("qoff", rows[i][18], qoff);
      chk16("dq_oe", {16{rows[i][19] & ~rows[i][18]}}, dq_oe);
    end
    m.strobe(0, lvl);
    chk16("dq_idle", 16'h0000, dq);
    m.mrs(2'h1, 16'h0080);
    chk1("undef_entry", 1'b1, undef);
    chk16("dq_oe_lvl", 16'hFFFF, dq_oe);
    m.odt_out <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    chk1("rtt_dqs", 1'b1, rtt_dqs);
    chk1("rtt_dq", 1'b0, rtt_dq);
    prev = 1'b1;
    locked = 1'b0;
    for (d = 0; d < 12 && !locked; d = d + 1) begin
      @(negedge ck);
      repeat (d + 1) @(posedge sys_clk_in);
      m.strobe(0, lvl);
      chk1("fb_lane0", lvl, dq[0]);
      chk16("dq_others", 16'h0000, dq & 16'hFEFE);
      locked = !prev && dq[0];
      prev = dq[0];
    end
    chk1("locked", 1'b1, locked);
    chk1("undef_fb", 1'b0, undef);
    @(posedge ck);
    @(posedge sys_clk_in);
    m.strobe(1, lvl);
    chk1("fb_lane1", lvl, dq[8]);
    chk1("lane0_held", 1'b1, dq[0]);
    @(negedge ck);
    @(posedge sys_clk_in);
    m.strobe(0, lvl);
    chk1("fb_lane0_lo", lvl, dq[0]);
    chk1("lane1_held", 1'b1, dq[8]);
    chk1("read_strobe", 1'b0, |dqs_oe);
    m.odt_out <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    chk1("rtt_dqs_off", 1'b0, rtt_dqs);
    m.mrs(2'h1, 16'h0000);
    chk1("exit_mode", 1'b0, lvl_mode);
    chk1("undef_hold", 1'b1, undef);
    @(posedge sys_clk_in);
    chk16("dq_exit", 16'h0000, dq);
    chk1("undef_exit", 1'b0, undef);
    m.odt_out <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    chk1("rtt_dq_norm", 1'b1, rtt_dq);
    complete_run;
  end
endmodule
